// File: rtl/ars_pkg.sv
//Contract
// [R1] SPI data valid 129 conversions after restart.
// [R2] Frame-sync restart latency 127 to 128 conversions.
// [R3] Host holds channel sleep low two clocks.
// [R4] All asleep: bias off, outputs stay driven.
// [R5] SPI, all channels asleep: ready pin high.
// [R6] Wake latency 129-130 SPI, 128-129 frame-sync; code counts 129 conversions in frame-sync too.
// [R7] Wake/sleep leaves running channels undisturbed.
// [R8] Woken channels aligned without restart pulse.
// [R9] TDM: fixed slot zero, dynamic slots packed.
// [R10] Per-pin format: sleeping channel drives zero.
// [R11] Dynamic TDM: waking channel joins when valid.
// [R12] Three format bits select seven output formats.
// [R13] Read-only SPI, ready falls, MSB first.
// [R14] Host uses SPI only up to 27MHz.
// [R15] Host serial clock up to master clock.
// [R16] Host waits one clock before first rising.
// [R17] Ready low on data, high first falling.
// [R18] Unread data: ready pulses high before next.
// [R19] Load one clock before ready falls; overwrite.
// [R20] Chain input sampled falling, follows own data.
// [R21] Modulator mode: clock out, raw bitstreams out.
// [R22] Restart low halts, resets filter counters.
// [R23] SPI: ready high during restart and settling.
// [R24] Frame-sync: data low during restart and settling.
// [R25] Host restart pulse one clock; 111 reserved.
package ars_pkg;

    localparam int CHANNELS = 8;
    localparam int WORD_BITS = 24;
    localparam int CNT_W = 10;
    localparam int MEM_AW = 8;
    localparam int TIMER_W = 9;
    localparam int SETTLE_W = 8;

    // Timer value ending each 512-cycle conversion period, and the timer value for the ready pulse.
    localparam logic [TIMER_W-1:0] CONV_LAST = 9'h1ff;
    localparam logic [TIMER_W-1:0] CONV_PULSE = 9'h1fe;

    // Conversion periods counted before data are declared valid.
    localparam logic [SETTLE_W-1:0] RESTART_SETTLE_SPI = 8'h81;
    localparam logic [SETTLE_W-1:0] RESTART_SETTLE_FS = 8'h80;
    localparam logic [SETTLE_W-1:0] WAKE_SETTLE_SPI = 8'h81;
    localparam logic [SETTLE_W-1:0] WAKE_SETTLE_FS = 8'h81;

    // Master clock cycles a sleep input must stay low to take effect.
    localparam logic [1:0] SLEEP_PULSE_WIDTH = 2'h2;

    localparam logic [CNT_W-1:0] WORD_BITS_CNT = 10'h018;
    localparam logic [CNT_W-1:0] FIXED_FRAME_BITS = 10'h0c0;

    typedef enum logic [2:0] {
        FMT_SPI_DYN = 3'b000,
        FMT_SPI_FIX = 3'b001,
        FMT_SPI_PIN = 3'b010,
        FMT_FS_DYN = 3'b011,
        FMT_FS_FIX = 3'b100,
        FMT_FS_PIN = 3'b101,
        FMT_MOD = 3'b110,
        FMT_RSVD = 3'b111
    } ars_format_e;

    typedef enum logic [1:0] {
        ST_HALT = 2'b00,
        ST_SETTLE = 2'b01,
        ST_RUN = 2'b10
    } ars_state_e;

endpackage

// File: rtl/ars_chain_if.sv
interface ars_chain_if;
    logic wr_en;
    logic [ars_pkg::MEM_AW-1:0] wr_addr;
    logic wr_bit;
    logic [ars_pkg::MEM_AW-1:0] rd_addr;
    logic rd_bit;

    modport link (output wr_en, output wr_addr, output wr_bit);
    modport reader (output rd_addr, input rd_bit);
    modport mem (input wr_en, input wr_addr, input wr_bit, input rd_addr, output rd_bit);
endinterface

// File: rtl/ars_chain_mem.sv
// Chain bit store: written from the serial clock domain, read in the master domain.
module ars_chain_mem (
    input wire logic wr_clk_i,
    input wire logic rd_clk_i,
    input wire logic rstn_i,
    ars_chain_if.mem bus
);

    logic store [2**ars_pkg::MEM_AW];
    logic rd_bit_reg;

    // Writes follow the falling serial clock edge, where the chain input is sampled.
    always_ff @(negedge wr_clk_i)
    begin
        if (bus.wr_en)
        begin
            store[bus.wr_addr] <= bus.wr_bit;
        end
    end

    always_ff @(posedge rd_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rd_bit_reg <= 1'b0;
        end
        else
        begin
            rd_bit_reg <= store[bus.rd_addr];
        end
    end

    assign bus.rd_bit = rd_bit_reg;

endmodule

// File: rtl/ars_top.sv
module ars_top (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic link_clk_i,
    output logic sclk_out_o,
    output logic sclk_oe_o,
    input wire logic restart_n_i,
    input wire logic [ars_pkg::CHANNELS-1:0] channel_sleep_n_i,
    input wire logic [2:0] format_i,
    input wire logic ready_or_frame_pin_i,
    output logic ready_or_frame_pin_o,
    output logic ready_or_frame_pin_oe_o,
    input wire logic chain_in_i,
    input wire logic [ars_pkg::CHANNELS*ars_pkg::WORD_BITS-1:0] sample_data_i,
    input wire logic [ars_pkg::CHANNELS-1:0] modulator_bits_i,
    output logic [ars_pkg::CHANNELS-1:0] serial_out_o,
    output logic bias_enable_o,
    output logic [ars_pkg::CHANNELS-1:0] channel_valid_o
);

    localparam int CH = ars_pkg::CHANNELS;
    localparam int CW = ars_pkg::CNT_W;

    ars_chain_if chain ();

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock domain: edge counter and chain input capture.

    logic [CW-1:0] link_cnt_reg;
    logic [CW-1:0] link_gray_reg;
    logic [CW-1:0] link_cnt_next;

    assign link_cnt_next = link_cnt_reg + 10'h001;

    // The edge count crosses as gray code so a late sample is off by one edge at most.
    always_ff @(negedge link_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            link_cnt_reg <= '0;
            link_gray_reg <= '0;
        end
        else
        begin
            link_cnt_reg <= link_cnt_next;
            link_gray_reg <= link_cnt_next ^ (link_cnt_next >> 1);
        end
    end

    // [R20] chain input capture
    assign chain.wr_en = 1'b1;
    assign chain.wr_addr = link_cnt_next[ars_pkg::MEM_AW-1:0];
    assign chain.wr_bit = chain_in_i;

    ars_chain_mem u_chain_mem (
        .wr_clk_i(link_clk_i),
        .rd_clk_i(clock_i),
        .rstn_i(rstn_i),
        .bus(chain)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic restart_meta, restart_sync;
    logic [CH-1:0] sleep_meta, sleep_sync;
    logic [2:0] fmt_meta, fmt_sync;
    logic strobe_meta, strobe_sync, strobe_prev;
    logic [CW-1:0] gray_meta, gray_sync;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            restart_meta <= 1'b0;
            restart_sync <= 1'b0;
            sleep_meta <= '0;
            sleep_sync <= '0;
            fmt_meta <= 3'h0;
            fmt_sync <= 3'h0;
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            strobe_prev <= 1'b0;
            gray_meta <= '0;
            gray_sync <= '0;
        end
        else
        begin
            restart_meta <= restart_n_i;
            restart_sync <= restart_meta;
            sleep_meta <= channel_sleep_n_i;
            sleep_sync <= sleep_meta;
            fmt_meta <= format_i;
            fmt_sync <= fmt_meta;
            strobe_meta <= ready_or_frame_pin_i;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
            gray_meta <= link_gray_reg;
            gray_sync <= gray_meta;
        end
    end

    function automatic logic [CW-1:0] gray_to_bin(input logic [CW-1:0] g);
        logic [CW-1:0] b;
        b = '0;
        b[CW-1] = g[CW-1];
        for (int i = CW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Format decode and conversion timing.

    ars_pkg::ars_format_e fmt;
    logic is_spi, is_fs, is_mod, is_pin, is_fix;

    // [R12] format decode
    assign fmt = ars_pkg::ars_format_e'(fmt_sync);
    assign is_spi = (fmt == ars_pkg::FMT_SPI_DYN) || (fmt == ars_pkg::FMT_SPI_FIX) ||
                    (fmt == ars_pkg::FMT_SPI_PIN);
    assign is_fs = (fmt == ars_pkg::FMT_FS_DYN) || (fmt == ars_pkg::FMT_FS_FIX) ||
                   (fmt == ars_pkg::FMT_FS_PIN);
    assign is_mod = (fmt == ars_pkg::FMT_MOD);
    assign is_pin = (fmt == ars_pkg::FMT_SPI_PIN) || (fmt == ars_pkg::FMT_FS_PIN);
    assign is_fix = (fmt == ars_pkg::FMT_SPI_FIX) || (fmt == ars_pkg::FMT_FS_FIX);

    ars_pkg::ars_state_e state_reg;
    logic [ars_pkg::TIMER_W-1:0] timer_reg;
    logic [ars_pkg::SETTLE_W-1:0] settle_reg;
    logic [ars_pkg::SETTLE_W-1:0] restart_thr, wake_thr;
    logic tick, run_now;

    assign restart_thr = is_fs ? ars_pkg::RESTART_SETTLE_FS : ars_pkg::RESTART_SETTLE_SPI;
    assign wake_thr = is_fs ? ars_pkg::WAKE_SETTLE_FS : ars_pkg::WAKE_SETTLE_SPI;
    // In frame-sync the host strobe sets the conversion boundary, otherwise the timer does.
    assign tick = (state_reg != ars_pkg::ST_HALT) &&
                  (is_fs ? (strobe_sync && !strobe_prev) : (timer_reg == ars_pkg::CONV_LAST));
    // [R1] [R2] settled on the last counted boundary
    assign run_now = (state_reg == ars_pkg::ST_RUN) ||
                     ((state_reg == ars_pkg::ST_SETTLE) && tick &&
                      (settle_reg == restart_thr - 8'h01));

    // [R22] restart halts and clears the timer
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            timer_reg <= '0;
        end
        else if (!restart_sync)
        begin
            timer_reg <= '0;
        end
        else
        begin
            timer_reg <= timer_reg + 9'h001;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_reg <= ars_pkg::ST_HALT;
            settle_reg <= '0;
        end
        else if (!restart_sync)
        begin
            state_reg <= ars_pkg::ST_HALT;
            settle_reg <= '0;
        end
        else
        begin
            case (state_reg)
                ars_pkg::ST_HALT:
                begin
                    state_reg <= ars_pkg::ST_SETTLE;
                end
                ars_pkg::ST_SETTLE:
                begin
                    if (run_now)
                    begin
                        state_reg <= ars_pkg::ST_RUN;
                    end
                    else if (tick)
                    begin
                        settle_reg <= settle_reg + 8'h01;
                    end
                end
                ars_pkg::ST_RUN:
                begin
                    state_reg <= ars_pkg::ST_RUN;
                end
                default:
                begin
                    state_reg <= ars_pkg::ST_HALT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel sleep filter and wake settling.

    logic [CH-1:0] awake;
    logic [CH-1:0] ch_ok;

    generate
        for (genvar c = 0; c < CH; c++)
        begin : g_chan
            logic [1:0] low_cnt_reg;
            logic awake_reg;
            logic [ars_pkg::SETTLE_W-1:0] wake_cnt_reg;

            // [R3] sleep needs two clocks low
            always_ff @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    low_cnt_reg <= 2'h0;
                    awake_reg <= 1'b1;
                end
                else if (sleep_sync[c])
                begin
                    low_cnt_reg <= 2'h0;
                    awake_reg <= 1'b1;
                end
                else if (low_cnt_reg == ars_pkg::SLEEP_PULSE_WIDTH - 2'h1)
                begin
                    awake_reg <= 1'b0;
                end
                else
                begin
                    low_cnt_reg <= low_cnt_reg + 2'h1;
                end
            end

            // [R6] [R8] wake settling counted on the shared boundary
            always_ff @(posedge clock_i or negedge rstn_i)
            begin
                if (!rstn_i)
                begin
                    wake_cnt_reg <= ars_pkg::WAKE_SETTLE_SPI;
                end
                else if (!awake_reg)
                begin
                    wake_cnt_reg <= '0;
                end
                else if (state_reg == ars_pkg::ST_HALT)
                begin
                    wake_cnt_reg <= wake_thr;
                end
                else if (tick && (wake_cnt_reg < wake_thr))
                begin
                    wake_cnt_reg <= wake_cnt_reg + 8'h01;
                end
            end

            assign awake[c] = awake_reg;
            assign ch_ok[c] = awake_reg && ((wake_cnt_reg >= wake_thr) ||
                              (tick && (wake_cnt_reg == wake_thr - 8'h01)));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Frame load, edge index and ready pin.

    logic [ars_pkg::WORD_BITS-1:0] snap_reg [CH];
    logic [CH-1:0] snap_mask_reg;
    logic [CW-1:0] base_reg, edges_now, idx, idx_reg, own_bits;
    logic load_reg, ready_reg;
    logic [CH-1:0] load_mask;

    assign edges_now = gray_to_bin(gray_sync);
    assign idx = edges_now - base_reg;
    assign load_mask = (is_spi || is_fs) && run_now ? ch_ok : '0;

    // [R19] new data loaded one clock before ready falls
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int c = 0; c < CH; c++)
            begin
                snap_reg[c] <= '0;
            end
            snap_mask_reg <= '0;
            base_reg <= '0;
            load_reg <= 1'b0;
        end
        else
        begin
            load_reg <= tick;
            if (tick)
            begin
                // [R7] [R10] sleeping or settling channels load zero
                for (int c = 0; c < CH; c++)
                begin
                    snap_reg[c] <= load_mask[c] ?
                        sample_data_i[c*ars_pkg::WORD_BITS +: ars_pkg::WORD_BITS] : '0;
                end
                snap_mask_reg <= load_mask;
                base_reg <= edges_now;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ready_reg <= 1'b1;
            idx_reg <= '0;
        end
        else
        begin
            idx_reg <= idx;
            // [R5] [R23] ready held high while halted, settling or all asleep
            if (!is_spi || (state_reg != ars_pkg::ST_RUN) || !(|awake))
            begin
                ready_reg <= 1'b1;
            end
            // [R18] short high pulse ahead of the next load
            else if (timer_reg == ars_pkg::CONV_PULSE)
            begin
                ready_reg <= 1'b1;
            end
            // [R13] [R17] falls on a fresh sample set
            else if (load_reg)
            begin
                ready_reg <= ~|snap_mask_reg;
            end
            // [R17] first falling serial edge clears it
            else if (idx != '0)
            begin
                ready_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output lanes.

    function automatic logic [2:0] nth_valid(input logic [CH-1:0] m, input int n);
        logic [2:0] sel;
        int seen;
        sel = 3'h0;
        seen = 0;
        for (int c = 0; c < CH; c++)
        begin
            if (m[c])
            begin
                if (seen == n)
                begin
                    sel = 3'(c);
                end
                seen++;
            end
        end
        return sel;
    endfunction

    // [R9] fixed keeps all slots, dynamic counts only valid ones
    assign own_bits = is_fix ? ars_pkg::FIXED_FRAME_BITS :
                      CW'($countones(snap_mask_reg)) * ars_pkg::WORD_BITS_CNT;
    localparam int MEM_ADDR = ars_pkg::MEM_AW;
    assign chain.rd_addr = MEM_ADDR'(edges_now + 10'h001 - own_bits);

    logic [CH-1:0] lane_next;

    always_comb
    begin
        int slot;
        int pos;
        logic [2:0] ch;
        slot = 0;
        pos = 0;
        ch = 3'h0;
        lane_next = '0;
        // [R21] modulator bitstreams straight to the lanes
        if (is_mod)
        begin
            lane_next = modulator_bits_i;
        end
        // [R4] [R24] lanes stay driven low while halted, settling or idle
        else if ((state_reg == ars_pkg::ST_RUN) && (|awake) && (is_spi || is_fs))
        begin
            if (is_pin)
            begin
                for (int c = 0; c < CH; c++)
                begin
                    if (awake[c] && (idx_reg < ars_pkg::WORD_BITS_CNT))
                    begin
                        lane_next[c] = snap_reg[c][ars_pkg::WORD_BITS - 1 - int'(idx_reg)];
                    end
                end
            end
            else if (idx_reg < own_bits)
            begin
                slot = int'(idx_reg) / ars_pkg::WORD_BITS;
                pos = int'(idx_reg) % ars_pkg::WORD_BITS;
                // [R11] dynamic frame uses the loaded valid mask
                ch = is_fix ? 3'(slot) : nth_valid(snap_mask_reg, slot);
                lane_next[0] = snap_reg[ch][ars_pkg::WORD_BITS - 1 - pos];
            end
            else
            begin
                // [R20] chain bits follow own data
                lane_next[0] = chain.rd_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pins.

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            serial_out_o <= '0;
            ready_or_frame_pin_o <= 1'b1;
            ready_or_frame_pin_oe_o <= 1'b0;
            sclk_out_o <= 1'b0;
            sclk_oe_o <= 1'b0;
            bias_enable_o <= 1'b0;
            channel_valid_o <= '0;
        end
        else
        begin
            serial_out_o <= lane_next;
            ready_or_frame_pin_o <= ready_reg;
            // Frame-sync turns the shared pin into the strobe input.
            ready_or_frame_pin_oe_o <= !is_fs;
            // [R21] modulator clock driven out at half the master clock
            sclk_out_o <= is_mod ? ~sclk_out_o : 1'b0;
            sclk_oe_o <= is_mod;
            // [R4] bias off once every channel sleeps
            bias_enable_o <= |awake;
            channel_valid_o <= snap_mask_reg;
        end
    end

endmodule

// File: sim/ars_props.sv
module ars_props (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic restart_n_i,
    input wire logic [ars_pkg::CHANNELS-1:0] channel_sleep_n_i,
    input wire logic [2:0] format_i,
    input wire logic [ars_pkg::CHANNELS-1:0] modulator_bits_i,
    input wire logic sclk_out_o,
    input wire logic sclk_oe_o,
    input wire logic ready_or_frame_pin_o,
    input wire logic ready_or_frame_pin_oe_o,
    input wire logic [ars_pkg::CHANNELS-1:0] serial_out_o,
    input wire logic bias_enable_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    // Repetition counts cover the two-stage input synchronisers.
    logic spi;
    logic fsy;
    assign spi = format_i inside {3'b000, 3'b001, 3'b010};
    assign fsy = format_i inside {3'b011, 3'b100, 3'b101};

    ////////////////////////////////////////////////////////////
    a_bias_all_asleep: assert property ((channel_sleep_n_i == 8'h00) [*8] |-> !bias_enable_o)
        else $error("bias on with all asleep");
    a_bias_any_awake: assert property ((|channel_sleep_n_i) [*8] |-> bias_enable_o)
        else $error("bias off with a channel awake");
    a_ready_all_asleep: assert property ((spi && channel_sleep_n_i == 8'h00) [*8]
        |-> ready_or_frame_pin_o && ready_or_frame_pin_oe_o)
        else $error("ready not high with all asleep");
    a_ready_in_restart: assert property ((spi && !restart_n_i) [*6] |-> ready_or_frame_pin_o)
        else $error("ready low during restart");
    a_fs_lanes_low: assert property ((fsy && !restart_n_i) [*6] |-> serial_out_o == 8'h00)
        else $error("lanes not low during restart");
    a_pin_drive_format: assert property (($stable(format_i) && format_i != 3'b111) [*6]
        |-> ready_or_frame_pin_oe_o == !fsy)
        else $error("ready pin drive wrong for format");
    a_mod_passes_bits: assert property ((format_i == 3'b110) [*6]
        |-> serial_out_o == $past(modulator_bits_i) && sclk_oe_o)
        else $error("modulator bits not passed");
    a_mod_clock_toggle: assert property ((format_i == 3'b110) [*6] |=> sclk_out_o != $past(sclk_out_o))
        else $error("modulator clock stuck");
    a_sleep_lane_zero: assert property ((format_i == 3'b010 && $stable(channel_sleep_n_i)) [*8]
        |-> (serial_out_o & ~channel_sleep_n_i) == 8'h00)
        else $error("sleeping lane not zero");

    cover property (spi ##1 $fell(ready_or_frame_pin_o));
    cover property (format_i == 3'b110 && sclk_oe_o);
    cover property (channel_sleep_n_i == 8'h00 && ready_or_frame_pin_o);
endmodule

bind ars_top ars_props u_props (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .restart_n_i(restart_n_i),
    .channel_sleep_n_i(channel_sleep_n_i),
    .format_i(format_i),
    .modulator_bits_i(modulator_bits_i),
    .sclk_out_o(sclk_out_o),
    .sclk_oe_o(sclk_oe_o),
    .ready_or_frame_pin_o(ready_or_frame_pin_o),
    .ready_or_frame_pin_oe_o(ready_or_frame_pin_oe_o),
    .serial_out_o(serial_out_o),
    .bias_enable_o(bias_enable_o)
);

// File: sim/ars_host.sv
module ars_host (
    input wire logic clock_i,
    input wire logic lane_i,
    output logic link_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [47:0] got_reg;

    initial link_clk_o = 1'b0;

    ////////////////////////////////////////////////////////////
    task automatic read_bits(input int nbits);
        got_reg = 48'h0;
        @(posedge clock_i);
        @(posedge clock_i);
        #13;
        for (int k = 0; k < nbits; k++)
        begin
            link_clk_o = 1'b1;
            got_reg = {got_reg[46:0], lane_i};
            #80;
            link_clk_o = 1'b0;
            // The low phase rests longer because output bits lag the falling edge.
            #280;
        end
    endtask
endmodule

// File: sim/test_adc_readout_sync_powerdown_iface.sv
module test_adc_readout_sync_powerdown_iface;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] AWAKE = 8'hf6;
    logic clock_i;
    logic rstn_i;
    logic restart_n_i;
    logic [7:0] channel_sleep_n_i;
    logic [2:0] format_i;
    logic chain_in_i;
    logic [191:0] sample_data_i;
    logic [7:0] modulator_bits_i;
    logic [7:0] serial_out_o;
    logic ready_or_frame_pin_o;
    logic ready_or_frame_pin_oe_o;
    logic bias_enable_o;
    logic [7:0] channel_valid_o;
    logic link_clk;
    logic pin;
    logic [191:0] rnd;
    logic [191:0] cur;
    logic [7:0] mb_prev;
    logic [2:0] fmt;
    int seed = 27016;
    int num_errors;
    int checks_done;
    int n;
    int lane_sel;

    // The host holds the frame strobe low whenever the pin is released.
    assign pin = ready_or_frame_pin_oe_o ? ready_or_frame_pin_o : 1'b0;

    ars_top dut (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .link_clk_i(link_clk),
        .sclk_out_o(),
        .sclk_oe_o(),
        .restart_n_i(restart_n_i),
        .channel_sleep_n_i(channel_sleep_n_i),
        .format_i(format_i),
        .ready_or_frame_pin_i(pin),
        .ready_or_frame_pin_o(ready_or_frame_pin_o),
        .ready_or_frame_pin_oe_o(ready_or_frame_pin_oe_o),
        .chain_in_i(chain_in_i),
        .sample_data_i(sample_data_i),
        .modulator_bits_i(modulator_bits_i),
        .serial_out_o(serial_out_o),
        .bias_enable_o(bias_enable_o),
        .channel_valid_o(channel_valid_o)
    );

    ars_host host (
        .clock_i(clock_i),
        .lane_i(serial_out_o[lane_sel]),
        .link_clk_o(link_clk)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        modulator_bits_i <= 8'($random(seed));
        chain_in_i <= 1'($random(seed));
        rnd <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
            $random(seed)};
    end

    ////////////////////////////////////////////////////////////
    function automatic logic [47:0] exp_lane(input logic [2:0] f, input logic [191:0] d);
        logic [47:0] r;
        int k;
        r = 48'h0;
        k = 0;
        if (f == 3'b010)
            return {d[47:24], 24'h000000};
        for (int c = 0; c < 8; c++)
        begin
            if (k < 2 && (f == 3'b001 || AWAKE[c]))
            begin
                r = {r[23:0], AWAKE[c] ? d[24*c+:24] : 24'h000000};
                k++;
            end
        end
        return r;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check_word(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic wait_ready(input logic lvl, input int bound);
        n = 0;
        while (ready_or_frame_pin_o !== lvl)
        begin
            @(negedge clock_i);
            n++;
            if (n > bound)
            begin
                num_errors++;
                $display("[FAIL] %0t ready wait ran out", $time);
                report_and_stop();
            end
        end
    endtask

    initial
    begin
        rstn_i = 1'b0;
        restart_n_i = 1'b1;
        channel_sleep_n_i = 8'hff;
        format_i = 3'b110;
        chain_in_i = 1'b0;
        sample_data_i = 192'h0;
        modulator_bits_i = 8'h00;
        num_errors = 0;
        checks_done = 0;
        lane_sel = 0;
        repeat (4) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        mb_prev = modulator_bits_i;
        repeat (10)
        begin
            @(negedge clock_i);
            check_word({40'h0, serial_out_o}, {40'h0, mb_prev});
            mb_prev = modulator_bits_i;
        end
        $display("test modulator done");
        @(posedge clock_i);
        format_i <= 3'b011;
        restart_n_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        check_word({40'h0, serial_out_o}, 48'h0);
        check_flag(ready_or_frame_pin_oe_o, 1'b0);
        @(posedge clock_i);
        format_i <= 3'b000;
        channel_sleep_n_i <= 8'h00;
        repeat (10) @(posedge clock_i);
        @(negedge clock_i);
        check_flag(ready_or_frame_pin_o, 1'b1);
        check_flag(bias_enable_o, 1'b0);
        $display("test all asleep done");
        @(posedge clock_i);
        cur = rnd;
        sample_data_i <= cur;
        format_i <= 3'b001;
        channel_sleep_n_i <= AWAKE;
        restart_n_i <= 1'b1;
        wait_ready(1'b0, 131 * 512);
        check_flag(n <= 129 * 512 + 8, 1'b1);
        check_flag(bias_enable_o, 1'b1);
        $display("test restart done");
        fmt = 3'b001;
        for (int i = 0; i < 6; i++)
        begin
            wait_ready(1'b0, 520);
            lane_sel = (fmt == 3'b010) ? 1 : 0;
            host.read_bits(48);
            check_word(host.got_reg, exp_lane(fmt, cur));
            check_flag(ready_or_frame_pin_o, 1'b1);
            check_word({40'h0, channel_valid_o}, {40'h0, AWAKE});
            fmt = (fmt == 3'b010) ? 3'b000 : fmt + 3'b001;
            @(posedge clock_i);
            cur = rnd;
            sample_data_i <= cur;
            format_i <= fmt;
        end
        $display("test frames done");
        wait_ready(1'b0, 520);
        @(posedge clock_i);
        cur = rnd;
        sample_data_i <= cur;
        wait_ready(1'b1, 520);
        check_flag(n > 400, 1'b1);
        wait_ready(1'b0, 4);
        lane_sel = (fmt == 3'b010) ? 1 : 0;
        host.read_bits(48);
        check_word(host.got_reg, exp_lane(fmt, cur));
        $display("test overrun done");
        report_and_stop();
    end
endmodule
